// ### hw/clk_switch_consts.vh
// constants for the master-clock source switch and synthesizer control
`ifndef CLK_SWITCH_CONSTS_VH
`define CLK_SWITCH_CONSTS_VH

// ==========================================================================
// timing
`define CLK_HZ 40000000
`define QUIET_TIME_US 150
`define QUIET_CYCLES ((`QUIET_TIME_US * (`CLK_HZ / 1000000)))
`define SYNTH_SETTLE_US 800
`define SYNTH_SETTLE_CYCLES ((`SYNTH_SETTLE_US * (`CLK_HZ / 1000000)))

// ==========================================================================
// clock-switch state encoding (gray: one bit changes per step)
`define SW_STATE_RCO 2'h0
`define SW_STATE_TRANS 2'h1
`define SW_STATE_BCLK 2'h3

// ==========================================================================
// synthesizer field encodings
`define MODE_BYPASS_ALL 2'h3
`define MODE_SCALE_500 2'h1
`define MODE_SCALE_1029 2'h2
`define PRESCALE_DIV1 2'h0
`define PRESCALE_DIV4 2'h2
`define PRESCALE_DIV8 2'h3
`define SOURCE_DIRECT 1'h0
`define SOURCE_SYNTH 1'h1

// ==========================================================================
// reset values of the decoded ratio outputs
`define PRESCALE_RATIO_RESET 4'h1
`define OUTPUT_DIV_RESET 8'h10

`endif

// ### hw/bit_sync.v
// two flip-flop level synchroniser
module bit_sync (
    input wire clk, // system clock
    input wire rst, // async reset, active high
    input wire din, // asynchronous level
    output reg dout // synchronised level
);
    reg meta_reg;

    // first stage feeds only the second stage
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            meta_reg <= 1'b0;
            dout <= 1'b0;
        end else begin
            meta_reg <= din;
            dout <= meta_reg;
        end
    end
endmodule // bit_sync

// ### hw/quiet_timer.v
// one-shot down counter that flags a run of a given number of cycles
module quiet_timer #(
    parameter WIDTH = 16 // counter width
) (
    input wire clk, // system clock
    input wire rst, // async reset, active high
    input wire start, // load pulse
    input wire [WIDTH-1:0] load_val, // cycles to count
    output wire busy, // counting
    output wire done // one-cycle pulse at expiry
);
    reg [WIDTH-1:0] count_reg;
    reg done_reg;

    // counts down to zero; a fresh start restarts the run
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            count_reg <= {WIDTH{1'b0}};
            done_reg <= 1'b0;
        end else begin
            done_reg <= (count_reg == {{(WIDTH-1){1'b0}}, 1'b1}) && !start;
            if (start) begin
                count_reg <= load_val;
            end else if (count_reg != {WIDTH{1'b0}}) begin
                count_reg <= count_reg - {{(WIDTH-1){1'b0}}, 1'b1};
            end
        end
    end

    assign busy = (count_reg != {WIDTH{1'b0}});
    assign done = done_reg;
endmodule // quiet_timer

// ### hw/mclk_source_switch.v
// master-clock source switch state machine and synthesizer control
`include "clk_switch_consts.vh"

module mclk_source_switch #(
    parameter QUIET_CYCLES = `QUIET_CYCLES, // 150 us quiet time in clocks
    parameter SETTLE_CYCLES = `SYNTH_SETTLE_CYCLES, // 800 us synthesizer settle
    parameter TW = 16 // timer width
) (
    input wire clk, // 40 MHz control clock
    input wire rst, // async reset, active high
    input wire clock_present, // software clock-present bit
    input wire i2c_stop, // one-cycle pulse: I2C stop seen
    input wire i2c_busy, // I2C transaction outstanding
    input wire bit_clock_running, // pin-domain activity level (async)
    input wire master_clock_source_select, // 0 direct pin, 1 synthesizer
    input wire synth_start, // synthesizer start bit
    input wire synth_reference_invert, // invert synthesizer reference
    input wire [1:0] reference_prescaler, // 0x0 /1, 0x2 /4, 0x3 /8
    input wire [7:0] synth_output_divider, // divide ratio equals value
    input wire [1:0] synth_mode, // multiplier mode
    output reg [1:0] clock_switch_state, // gray-coded switch state
    output reg oscillator_powerdown_state, // 1 while oscillator powered down
    output reg sel_bit_clock, // glitchless mux: 1 picks bit clock path
    output reg sel_synth, // 1 routes synthesizer output to the mux
    output reg synth_power_on, // synthesizer analog enable
    output reg synth_ref_invert_out, // reference invert control
    output reg [3:0] prescale_ratio, // decoded prescale ratio
    output reg [7:0] output_div_ratio, // decoded output divide ratio
    output reg [1:0] scale_select, // 0 none, 1 500/512, 2 1029/1024
    output reg synth_settled, // 800 us passed since start
    output reg i2c_hold_off // I2C quiet window active
);
    // ======================================================================
    // states
    // one-hot, so each state test is a single flop
    localparam [3:0] ST_RCO = 4'h1;
    localparam [3:0] ST_WAIT = 4'h2;
    localparam [3:0] ST_SWITCH = 4'h4;
    localparam [3:0] ST_BCLK = 4'h8;

    reg [3:0] state_reg;
    reg [3:0] state_next;
    reg present_d_reg;
    reg target_reg;
    reg target_next;
    reg pending_reg;
    reg pending_next;
    reg synth_start_d_reg;
    // conditioned pin level and timer hand-offs
    wire bclk_sync;
    wire quiet_busy;
    wire quiet_done;
    wire settle_busy;
    wire settle_done;
    wire quiet_start;
    wire settle_start;
    wire present_edge;

    // ======================================================================
    // input conditioning
    // the activity level comes from the pin domain, so it is synchronised
    bit_sync u_bclk_sync (
        .clk(clk),
        .rst(rst),
        .din(bit_clock_running),
        .dout(bclk_sync)
    );

    // edge detect on the software bit (same clock domain)
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            present_d_reg <= 1'b0;
            synth_start_d_reg <= 1'b0;
        end else begin
            present_d_reg <= clock_present;
            synth_start_d_reg <= synth_start;
        end
    end

    assign present_edge = clock_present ^ present_d_reg;

    // ======================================================================
    // timers
    // the quiet window opens only on a clean stop while a switch waits
    assign quiet_start = (state_reg == ST_WAIT) && i2c_stop && !i2c_busy;
    // settle timing restarts on each rising start bit
    assign settle_start = synth_start && !synth_start_d_reg;

    // one timer per window; both load from parameters, never from ports
    quiet_timer #(.WIDTH(TW)) u_quiet (
        .clk(clk),
        .rst(rst),
        .start(quiet_start),
        .load_val(QUIET_CYCLES[TW-1:0]),
        .busy(quiet_busy),
        .done(quiet_done)
    );

    // settle timer runs independently of the switch machine
    quiet_timer #(.WIDTH(TW)) u_settle (
        .clk(clk),
        .rst(rst),
        .start(settle_start),
        .load_val(SETTLE_CYCLES[TW-1:0]),
        .busy(settle_busy),
        .done(settle_done)
    );

    // ======================================================================
    // switch state machine
    // a pending change is latched so an edge during a switch is not lost
    always @* begin
        state_next = state_reg;
        target_next = target_reg;
        pending_next = pending_reg;
        if (present_edge) begin
            pending_next = 1'b1;
        end
        case (state_reg)
            ST_RCO, ST_BCLK: begin
                if (pending_reg) begin
                    target_next = clock_present;
                    if (clock_present == (state_reg == ST_BCLK)) begin
                        // already where the bit points: nothing to do
                        pending_next = present_edge;
                    end else if (!clock_present || bclk_sync) begin
                        // going to the pin needs it running; otherwise stay pending
                        state_next = ST_WAIT;
                        pending_next = present_edge;
                    end
                end
            end
            ST_WAIT: begin
                // outstanding transactions finish first; stop starts the switch
                if (quiet_start) begin
                    state_next = ST_SWITCH;
                end else if (target_reg && !bclk_sync) begin
                    // pin lost before the stop: stay on the oscillator, retry later
                    state_next = ST_RCO;
                    pending_next = 1'b1;
                end
            end
            ST_SWITCH: begin
                // mux moves only after the quiet window, at its end
                if (quiet_done) begin
                    if (target_reg && !bclk_sync) begin
                        // never hand the core to a dead pin; keep the request open
                        state_next = ST_RCO;
                        pending_next = 1'b1;
                    end else begin
                        state_next = target_reg ? ST_BCLK : ST_RCO;
                    end
                end
            end
            default: begin
                state_next = ST_RCO;
                target_next = 1'b0;
                pending_next = 1'b0;
            end
        endcase
    end

    // reset always lands on the oscillator
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            state_reg <= ST_RCO;
            target_reg <= 1'b0;
            pending_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            target_reg <= target_next;
            pending_reg <= pending_next;
        end
    end

    // ======================================================================
    // status and mux control, all registered
    // gray code: RC_OSCILLATOR 00 -> TRANS 01 -> BCLK 11, one bit per step; while the
    // switch waits for its stop both status bits keep their old value
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            clock_switch_state <= `SW_STATE_RCO;
            oscillator_powerdown_state <= 1'b0;
        end else begin
            case (state_next)
                ST_BCLK: begin
                    clock_switch_state <= `SW_STATE_BCLK;
                    // oscillator sleeps only while the pin clock is in charge
                    oscillator_powerdown_state <= 1'b1;
                end
                ST_SWITCH: begin
                    clock_switch_state <= `SW_STATE_TRANS;
                    // a fall-back needs the oscillator up before the mux moves
                    oscillator_powerdown_state <= 1'b0;
                end
                ST_WAIT: begin
                    clock_switch_state <= clock_switch_state;
                    oscillator_powerdown_state <= oscillator_powerdown_state;
                end
                default: begin
                    clock_switch_state <= `SW_STATE_RCO;
                    oscillator_powerdown_state <= 1'b0;
                end
            endcase
        end
    end

    // single registered select feeds the glitchless mux cell; it moves only
    // on arrival, so the old source keeps clocking through wait and window;
    // the control port sits behind the same mux, so it shares the core rate
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            sel_bit_clock <= 1'b0;
        end else begin
            case (state_next)
                ST_BCLK: sel_bit_clock <= 1'b1;
                ST_RCO: sel_bit_clock <= 1'b0;
                default: sel_bit_clock <= sel_bit_clock;
            endcase
        end
    end

    // hold-off covers the quiet window from the starting stop to expiry
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            i2c_hold_off <= 1'b0;
        end else begin
            i2c_hold_off <= quiet_start || (quiet_busy && !quiet_done);
        end
    end

    // ======================================================================
    // synthesizer control decode
    // the mux select is sampled on every cycle, whatever the switch state,
    // so the synthesizer route can be picked before the switch completes
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            sel_synth <= 1'b0;
            synth_power_on <= 1'b0;
            synth_ref_invert_out <= 1'b0;
        end else begin
            sel_synth <= (master_clock_source_select == `SOURCE_SYNTH);
            // source 0 bypasses; clearing start powers the synthesizer down
            synth_power_on <= synth_start;
            synth_ref_invert_out <= synth_reference_invert;
        end
    end

    // ratio decode; the undefined prescaler code falls back to divide-by-2
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            prescale_ratio <= `PRESCALE_RATIO_RESET;
            output_div_ratio <= `OUTPUT_DIV_RESET;
            scale_select <= 2'h0;
        end else begin
            case (reference_prescaler)
                `PRESCALE_DIV1: prescale_ratio <= 4'h1;
                `PRESCALE_DIV4: prescale_ratio <= 4'h4;
                `PRESCALE_DIV8: prescale_ratio <= 4'h8;
                default: prescale_ratio <= 4'h2;
            endcase
            // odd divider values are the host's fault and pass unchanged
            output_div_ratio <= synth_output_divider;
            case (synth_mode)
                `MODE_SCALE_500: scale_select <= 2'h1;
                `MODE_SCALE_1029: scale_select <= 2'h2;
                `MODE_BYPASS_ALL: scale_select <= 2'h0;
                default: scale_select <= 2'h0;
            endcase
        end
    end

    // settle flag: a fresh start restarts the count, a cleared start drops it;
    // the host times its divider restore against this, not against a guess
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            synth_settled <= 1'b0;
        end else if (!synth_start || settle_start) begin
            synth_settled <= 1'b0;
        end else if (settle_done) begin
            synth_settled <= 1'b1;
        end
    end
endmodule // mclk_source_switch

// ### tb/mclk_switch_checker.sv
// port assertions for the master-clock source switch
module mclk_switch_checker #(
    parameter QUIET_CYCLES = 20, // quiet window length
    parameter SETTLE_CYCLES = 40 // synthesizer settle length
) (
    input wire clk, // clock
    input wire rst, // reset
    input wire i2c_stop, // stop pulse
    input wire i2c_busy, // transaction open
    input wire master_clock_source_select, // source select
    input wire synth_start, // start bit
    input wire [1:0] clock_switch_state, // switch state
    input wire oscillator_powerdown_state, // osc down
    input wire sel_bit_clock, // mux select
    input wire sel_synth, // synth route
    input wire synth_power_on, // synth enable
    input wire synth_settled, // settled flag
    input wire i2c_hold_off // quiet window
);
    timeunit 1ns;
    timeprecision 1ps;
    // =====
    // quiet bounds allow one cycle early and three late; settle bounds allow four late
    localparam int QLO = QUIET_CYCLES - 1;
    localparam int QHI = QUIET_CYCLES + 3;
    localparam int QM = QUIET_CYCLES - 2;
    localparam int SLO = SETTLE_CYCLES;
    localparam int SHI = SETTLE_CYCLES + 4;
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    gray_step_a: assert property ($countones(clock_switch_state ^ $past(clock_switch_state)) < 2)
        else $error("state changed more than one bit");
    state_code_a: assert property (clock_switch_state != 2'h2)
        else $error("unused state code");
    osc_down_a: assert property (oscillator_powerdown_state == (clock_switch_state == 2'h3))
        else $error("powerdown status wrong");
    mux_pin_a: assert property (clock_switch_state == 2'h3 |-> sel_bit_clock)
        else $error("pin state without pin mux");
    mux_osc_a: assert property (clock_switch_state == 2'h0 |-> !sel_bit_clock)
        else $error("oscillator state with pin mux");
    stop_start_a: assert property ($rose(i2c_hold_off) |-> $past(i2c_stop) && !$past(i2c_busy))
        else $error("switch began without stop");
    trans_quiet_a: assert property (clock_switch_state == 2'h1 |-> i2c_hold_off)
        else $error("transition without quiet window");
    quiet_min_a: assert property ($rose(i2c_hold_off) |-> ##QM i2c_hold_off)
        else $error("quiet window too short");
    quiet_end_a: assert property ($rose(i2c_hold_off) |-> ##[QLO:QHI] !i2c_hold_off)
        else $error("quiet window too long");
    mux_move_a: assert property ($changed(sel_bit_clock) |-> $changed(clock_switch_state))
        else $error("mux moved without a state step");
    src_follow_a: assert property (!$past(rst) |-> sel_synth == $past(master_clock_source_select))
        else $error("synth route not following select");
    power_follow_a: assert property (!$past(rst) |-> synth_power_on == $past(synth_start))
        else $error("synth power not following start");
    settle_time_a: assert property ($rose(synth_start) |-> ##[SLO:SHI] synth_settled)
        else $error("settle flag late");
endmodule // mclk_switch_checker

// ### tb/i2c_host_model.sv
// I2C host as seen by the switch: transactions end in a stop pulse
module i2c_host_model (
    input wire clk, // clock
    input wire go, // request one transaction
    input wire hold_off, // device quiet window
    output reg i2c_stop, // stop pulse
    output reg i2c_busy // transaction open
);
    timeunit 1ns;
    timeprecision 1ps;
    integer left = 0;
    initial begin
        i2c_stop = 1'b0;
        i2c_busy = 1'b0;
    end
    // =====
    // four busy cycles, then stop; requests wait out the quiet window
    always @(negedge clk) begin
        i2c_stop <= 1'b0;
        if (left > 0) begin
            left <= left - 1;
            i2c_busy <= (left > 1);
            i2c_stop <= (left == 1);
        end else if (go && !hold_off) begin
            left <= 4;
            i2c_busy <= 1'b1;
        end
    end
endmodule // i2c_host_model

// ### tb/mclk_source_switch_and_pll_tb.sv
// self-checking bench for the master-clock source switch
module mclk_source_switch_and_pll_tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam QC = 20;
    localparam SC = 40;
    reg clk = 1'b0;
    reg rst = 1'b1;
    reg present = 1'b0;
    reg running = 1'b0;
    reg src = 1'b0;
    reg start = 1'b0;
    reg inv = 1'b0;
    reg [1:0] pre = 2'h0;
    reg [7:0] div = 8'h10;
    reg [1:0] mode = 2'h0;
    reg go = 1'b0;
    wire stop, busy, pd, sel_b, sel_s, pwr, inv_o, settled, hold;
    wire [1:0] state;
    wire [1:0] scale;
    wire [3:0] pre_r;
    wire [7:0] div_r;
    integer err_count = 0;
    integer comparisons = 0;
    integer seed = 32'h2dc36d32;
    integer i;
    // =====
    // design and far side
    mclk_source_switch #(.QUIET_CYCLES(QC), .SETTLE_CYCLES(SC)) dut_u (.clk(clk), .rst(rst),
        .clock_present(present), .i2c_stop(stop), .i2c_busy(busy), .bit_clock_running(running),
        .master_clock_source_select(src), .synth_start(start), .synth_reference_invert(inv),
        .reference_prescaler(pre), .synth_output_divider(div), .synth_mode(mode),
        .clock_switch_state(state), .oscillator_powerdown_state(pd), .sel_bit_clock(sel_b),
        .sel_synth(sel_s), .synth_power_on(pwr), .synth_ref_invert_out(inv_o),
        .prescale_ratio(pre_r), .output_div_ratio(div_r), .scale_select(scale),
        .synth_settled(settled), .i2c_hold_off(hold));
    i2c_host_model host_u (.clk(clk), .go(go), .hold_off(hold), .i2c_stop(stop), .i2c_busy(busy));
    initial forever #12.5 clk = ~clk;
    // =====
    // helpers; expectations come from the encodings, not the design
    function [3:0] exp_pre(input [1:0] c);
        exp_pre = (c == 2'h0) ? 4'h1 : (c == 2'h2) ? 4'h4 : (c == 2'h3) ? 4'h8 : 4'h2;
    endfunction
    task check(input [7:0] got, input [7:0] exp);
        begin
            comparisons = comparisons + 1;
            if (got !== exp) begin
                err_count = err_count + 1;
                $display("wrong value at %0t: got %h expected %h", $time, got, exp);
            end
        end
    endtask
    task wait_state(input [1:0] want);
        integer n;
        begin
            n = 0;
            while (state !== want && n < 200) begin
                @(negedge clk);
                n = n + 1;
            end
        end
    endtask
    // go is set by nonblocking so the model never races the edge
    task xact;
        begin
            wait_state(state);
            while (hold !== 1'b0) @(negedge clk);
            go <= 1'b1;
            @(negedge clk);
            go <= 1'b0;
            repeat (3) @(negedge clk);
        end
    endtask
    task finish_test;
        begin
            $display("counts: %0d comparisons, %0d mismatches", comparisons, err_count);
            if (err_count == 0 && comparisons > 0) begin
                $display("ALL TESTS PASSED");
            end else begin
                $display("TESTS FAILED");
            end
            $finish;
        end
    endtask
    // =====
    // watchdog: the sequence needs well under a thousand cycles
    initial begin
        #(4000 * 25);
        err_count = err_count + 1;
        finish_test;
    end
    initial begin
        repeat (5) @(negedge clk);
        rst = 1'b0;
        check(state, 2'h0);
        check(pre_r, 4'h1);
        check(div_r, 8'h10);
        $display("test reset done");
        // every prescaler code and mode, random even dividers
        for (i = 0; i < 12; i = i + 1) begin
            pre = i[1:0] + i[3:2];
            mode = i[1:0];
            div = {$random(seed)} & 8'hFE;
            src = $random(seed);
            inv = $random(seed);
            repeat (2) @(negedge clk);
            check(pre_r, exp_pre(pre));
            check(scale, (mode == 2'h3) ? 2'h0 : mode);
            check(div_r, div);
            check(inv_o, inv);
            check(sel_s, src);
        end
        $display("test decode done");
        // pin lost before the stop: the request waits, no quiet window opens
        present = 1'b1;
        running = 1'b1;
        repeat (4) @(negedge clk);
        running = 1'b0;
        xact;
        repeat (QC + 5) @(negedge clk);
        check(state, 2'h0);
        check(hold, 1'b0);
        // pin running: switch waits for the stop, then the quiet window
        running = 1'b1;
        xact;
        check(state, 2'h0);
        wait_state(2'h1);
        check(hold, 1'b1);
        wait_state(2'h3);
        check(sel_b, 1'b1);
        check(pd, 1'b1);
        $display("test to pin done");
        // back to the oscillator with the pin kept running
        present = 1'b0;
        xact;
        wait_state(2'h0);
        check(sel_b, 1'b0);
        check(pd, 1'b0);
        running = 1'b0;
        $display("test to oscillator done");
        // reset while on the pin
        running = 1'b1;
        present = 1'b1;
        xact;
        wait_state(2'h3);
        rst = 1'b1;
        present = 1'b0;
        @(negedge clk);
        check(state, 2'h0);
        check(sel_b, 1'b0);
        rst = 1'b0;
        $display("test mid reset done");
        // synthesizer power-up in order: reference /4 x64, divider n-scaled to 16
        pre = 2'h2;
        div = 8'h10;
        mode = 2'h3;
        start = 1'b1;
        repeat (2) @(negedge clk);
        check(pwr, 1'b1);
        check(pre_r, 4'h4);
        check(scale, 2'h0);
        repeat (SC + 6) @(negedge clk);
        check(settled, 1'b1);
        // functional divider of 8 puts the master clock in the 24 MHz region
        div = 8'h08;
        repeat (2) @(negedge clk);
        check(div_r, 8'h08);
        start = 1'b0;
        repeat (3) @(negedge clk);
        check(pwr, 1'b0);
        check(settled, 1'b0);
        $display("test synth done");
        finish_test;
    end
endmodule // mclk_source_switch_and_pll_tb
bind mclk_source_switch mclk_switch_checker #(.QUIET_CYCLES(QUIET_CYCLES),
    .SETTLE_CYCLES(SETTLE_CYCLES)) chk_u (.clk(clk), .rst(rst), .i2c_stop(i2c_stop),
    .i2c_busy(i2c_busy), .master_clock_source_select(master_clock_source_select),
    .synth_start(synth_start), .clock_switch_state(clock_switch_state),
    .oscillator_powerdown_state(oscillator_powerdown_state), .sel_bit_clock(sel_bit_clock),
    .sel_synth(sel_synth), .synth_power_on(synth_power_on), .synth_settled(synth_settled),
    .i2c_hold_off(i2c_hold_off));
